// ==== src/emb_pkg.sv ====
// Package: constants and types for the external memory/IO bus
package emb_pkg;
  // ==========================================================
  // Widths and fixed values
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int WAIT_W = 3;
  localparam logic [3:0] HIGH_ADDR_ZERO = 4'h0;
  localparam logic [WAIT_W-1:0] MIN_HW_WAITS = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // ==========================================================
  // Access kinds
  typedef enum logic [1:0] {
    EMB_MEM_RD,
    EMB_MEM_WR,
    EMB_IO_RD,
    EMB_IO_WR
  } emb_kind_t;

  // Request from the core
  typedef struct packed {
    emb_kind_t kind;
    logic progSpace;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } emb_req_t;

  // Pin bundle toward the external bus
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic program_space_select_n;
    logic data_space_select_n;
    logic io_space_select_n;
    logic readWrite;
    logic memory_strobe_n;
    logic io_strobe_n;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } emb_pins_t;
endpackage : emb_pkg

// ==== src/emb_phase_gen.sv ====
// Clock-output generator giving half-cycle phase enables
`timescale 1ns/100ps
module emb_phase_gen
(
  input wire logic clock,
  input wire logic rst,
  output logic cpuClkOut,
  output logic riseEn,
  output logic fallEn
);
  logic phase_reg;
  logic phase_next;

  // ==========================================================
  // Clock output toggles each system cycle: H is one clock period
  always_comb
  begin
    phase_next = ~phase_reg;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      phase_reg <= 1'b0;
    else
      phase_reg <= phase_next;
  end

  assign cpuClkOut = phase_reg;
  // Enables mark the edge the clock output makes at the next clock
  assign riseEn = ~phase_reg;
  assign fallEn = phase_reg;
endmodule : emb_phase_gen

// ==== src/emb_bus_ctrl.sv ====
// External memory and I/O bus sequencer
`timescale 1ns/100ps
module emb_bus_ctrl
#(
  parameter logic [emb_pkg::WAIT_W-1:0] SW_WAITS = 3'h2
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reqValid,
  input wire emb_pkg::emb_req_t req,
  input wire logic consecutive_read_mode,
  input wire logic ready,
  input wire logic [emb_pkg::DATA_W-1:0] dataIn,
  output logic reqReady,
  output logic [emb_pkg::DATA_W-1:0] rdata,
  output logic rdataValid,
  output logic cpu_clock_out,
  output logic microstate_complete_n,
  output logic consecReadActive,
  output emb_pkg::emb_pins_t pins
);
  typedef enum {
    EMB_IDLE,
    EMB_SETUP,
    EMB_STROBE,
    EMB_WAIT,
    EMB_END,
    EMB_HOLD
  } emb_state_t;

  logic clkRaw;
  logic riseEn;
  logic fallEn;
  emb_state_t state_reg, state_next;
  emb_pkg::emb_req_t cur_reg, cur_next;
  emb_pkg::emb_pins_t pins_reg, pins_next;
  logic [emb_pkg::WAIT_W-1:0] wcnt_reg, wcnt_next;
  logic [emb_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic msc_reg, msc_next;
  logic reqReady_reg, reqReady_next;
  logic consecutive_read_mode_reg;

  emb_phase_gen u_phase
  (
    .clock(clock),
    .rst(rst),
    .cpuClkOut(clkRaw),
    .riseEn(riseEn),
    .fallEn(fallEn)
  );

  // Hardware waits allowed only with enough software waits
  function automatic logic hwWaitOk(input logic [emb_pkg::WAIT_W-1:0] n);
    hwWaitOk = (n >= emb_pkg::MIN_HW_WAITS);
  endfunction : hwWaitOk

  function automatic logic isIo(input emb_pkg::emb_kind_t k);
    isIo = (k == emb_pkg::EMB_IO_RD) || (k == emb_pkg::EMB_IO_WR);
  endfunction : isIo

  function automatic logic isWr(input emb_pkg::emb_kind_t k);
    isWr = (k == emb_pkg::EMB_MEM_WR) || (k == emb_pkg::EMB_IO_WR);
  endfunction : isWr

  // ==========================================================
  // Sequencer. Memory strobe on falling edges, I/O strobe on rising.
  always_comb
  begin
    state_next = state_reg;
    cur_next = cur_reg;
    pins_next = pins_reg;
    wcnt_next = wcnt_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    msc_next = 1'b1;
    case (state_reg)
      EMB_IDLE:
      begin
        // New cycles launch on a falling edge so address leads strobe
        if (reqValid && fallEn)
        begin
          cur_next = req;
          pins_next.addr = req.addr;
          if (!req.progSpace || isIo(req.kind))
            pins_next.addr[emb_pkg::ADDR_W-1 -: 4] =
              emb_pkg::HIGH_ADDR_ZERO;
          pins_next.program_space_select_n =
            ~(req.progSpace && !isIo(req.kind));
          pins_next.data_space_select_n =
            ~(!req.progSpace && !isIo(req.kind));
          pins_next.io_space_select_n = ~isIo(req.kind);
          // I/O write turns direction with the address, on the fall
          if (isIo(req.kind) && isWr(req.kind))
            pins_next.readWrite = 1'b0;
          state_next = EMB_SETUP;
        end
      end
      EMB_SETUP:
      begin
        // Memory write: direction low on rising edge, half before strobe
        if (riseEn && isWr(cur_reg.kind) && !isIo(cur_reg.kind))
          pins_next.readWrite = 1'b0;
        // Memory strobe one full cycle after address, once direction set
        if (!isIo(cur_reg.kind) && fallEn &&
            (pins_reg.readWrite != isWr(cur_reg.kind)))
        begin
          pins_next.memory_strobe_n = 1'b0;
          wcnt_next = SW_WAITS;
          state_next = EMB_STROBE;
        end
        // I/O strobe half a cycle after address, on a rising edge
        if (isIo(cur_reg.kind) && riseEn)
        begin
          pins_next.io_strobe_n = 1'b0;
          wcnt_next = SW_WAITS;
          state_next = EMB_STROBE;
        end
      end
      EMB_STROBE:
      begin
        // Data driven only while direction says write
        if (!pins_reg.readWrite && isWr(cur_reg.kind))
        begin
          pins_next.dataOut = cur_reg.wdata;
          pins_next.dataOe = 1'b1;
        end
        // Software waits counted in whole clock-output cycles
        if (fallEn)
        begin
          if (wcnt_reg != '0)
          begin
            wcnt_next = wcnt_reg - 3'h1;
            if (wcnt_reg == 3'h1)
              msc_next = 1'b0;
          end
          else
            state_next = EMB_WAIT;
        end
      end
      EMB_WAIT:
      begin
        // Ready only sampled after software waits and on a falling edge
        if (fallEn && (!hwWaitOk(SW_WAITS) || ready))
          state_next = EMB_END;
      end
      EMB_END:
      begin
        // I/O reads capture on rising edge, memory reads on falling
        if (isIo(cur_reg.kind) ? riseEn : fallEn)
        begin
          if (!isWr(cur_reg.kind))
          begin
            rdata_next = dataIn;
            rvalid_next = 1'b1;
          end
          pins_next.memory_strobe_n = 1'b1;
          pins_next.io_strobe_n = 1'b1;
          state_next = EMB_HOLD;
        end
      end
      EMB_HOLD:
      begin
        // Data held half a cycle past strobe, then bus released
        if (isIo(cur_reg.kind) ? fallEn : riseEn)
        begin
          pins_next.readWrite = 1'b1;
          pins_next.dataOe = 1'b0;
          pins_next.program_space_select_n = 1'b1;
          pins_next.data_space_select_n = 1'b1;
          pins_next.io_space_select_n = 1'b1;
          state_next = EMB_IDLE;
        end
      end
      default:
      begin
        state_next = EMB_IDLE;
      end
    endcase
    // Phase alternates, so a rising cycle now means a falling one next
    reqReady_next = (state_next == EMB_IDLE) && riseEn;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= EMB_IDLE;
      cur_reg <= '0;
      pins_reg <= '{addr: emb_pkg::ADDR_RESET, program_space_select_n: 1'b1,
        data_space_select_n: 1'b1, io_space_select_n: 1'b1,
        readWrite: 1'b1, memory_strobe_n: 1'b1, io_strobe_n: 1'b1,
        dataOut: emb_pkg::DATA_RESET, dataOe: 1'b0};
      wcnt_reg <= '0;
      rdata_reg <= emb_pkg::DATA_RESET;
      rvalid_reg <= 1'b0;
      msc_reg <= 1'b1;
      reqReady_reg <= 1'b0;
      consecutive_read_mode_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      pins_reg <= pins_next;
      wcnt_reg <= wcnt_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      msc_reg <= msc_next;
      reqReady_reg <= reqReady_next;
      consecutive_read_mode_reg <= consecutive_read_mode;
    end
  end

  // Registered outputs; the phase flop drives the clock pin directly so
  // strobes and address move at the very edge the clock output makes
  assign pins = pins_reg;
  assign rdata = rdata_reg;
  assign rdataValid = rvalid_reg;
  assign microstate_complete_n = msc_reg;
  assign cpu_clock_out = clkRaw;
  assign consecReadActive = consecutive_read_mode_reg;
  assign reqReady = reqReady_reg;

  // ==========================================================
  // Checks
  upper_addr_a: assert property (@(posedge clock) disable iff (rst)
    (!pins_reg.data_space_select_n || !pins_reg.io_space_select_n) |->
    pins_reg.addr[19:16] == 4'h0) else $error("upper address not low");
  io_upper_a: assert property (@(posedge clock) disable iff (rst)
    !pins_reg.io_strobe_n |-> pins_reg.addr[19:16] == 4'h0)
    else $error("io upper address not low");
  data_release_a: assert property (@(posedge clock) disable iff (rst)
    pins_reg.readWrite |-> !pins_reg.dataOe)
    else $error("data driven while read");
  // Two system clocks low is one whole clock-output cycle
  memory_strobe_n_width_a: assert property (@(posedge clock) disable iff (rst)
    $fell(pins_reg.memory_strobe_n) |-> (!pins_reg.memory_strobe_n)[*2])
    else $error("memory strobe too short");
  // Reads keep direction high, so only writes are held to the lead
  rw_lead_a: assert property (@(posedge clock) disable iff (rst)
    $fell(pins_reg.memory_strobe_n) && !pins_reg.readWrite |->
    !$past(pins_reg.readWrite))
    else $error("direction not ahead of strobe");
  // Ready is only looked at once the software count has run out
  no_ready_early_a: assert property (@(posedge clock)
    disable iff (rst) (state_reg == EMB_WAIT) |-> (wcnt_reg == '0))
    else $error("ready sampled before waits done");
  ready_stall_a: assert property (@(posedge clock) disable iff (rst)
    (state_reg == EMB_WAIT && fallEn && !ready && hwWaitOk(SW_WAITS))
    |=> state_reg == EMB_WAIT) else $error("ready low ignored");
  io_strobe_n_edge_a: assert property (@(posedge clock) disable iff (rst)
    $changed(pins_reg.io_strobe_n) |-> $past(riseEn))
    else $error("io strobe off rising edge");
  data_hold_a: assert property (@(posedge clock) disable iff (rst)
    $rose(pins_reg.memory_strobe_n) && isWr(cur_reg.kind) |->
    pins_reg.dataOe) else $error("write data dropped early");
endmodule : emb_bus_ctrl

// ==== dv/emb_bus_partner.sv ====
// Behavioural external memory and I/O peripheral for the bus sequencer
`timescale 1ns/100ps
module emb_bus_partner
(
  input wire logic clock,
  input wire logic rst,
  input wire emb_pkg::emb_pins_t pins,
  input wire logic [7:0] stallCycles,
  output logic ready,
  output logic [emb_pkg::DATA_W-1:0] dataIn
);
  logic [emb_pkg::DATA_W-1:0] memArr [0:15];
  logic [emb_pkg::DATA_W-1:0] lastData;
  logic [7:0] waitCnt;
  logic strobeLow;

  assign strobeLow = !pins.memory_strobe_n || !pins.io_strobe_n;
  // Ready low for stallCycles clocks after a strobe falls
  // Ready is already low as the strobe falls, so it is settled in time
  always @(posedge clock)
  begin
    if (rst || !strobeLow)
      waitCnt <= stallCycles;
    else if (waitCnt != 8'h00)
      waitCnt <= waitCnt - 8'h01;
    if (strobeLow && !pins.readWrite && pins.dataOe)
      memArr[pins.addr[3:0]] <= pins.dataOut;
    lastData <= rst ? 16'h0000 : dataIn;
  end
  assign ready = (waitCnt == 8'h00);
  // Released bus shows the inverse of its last value, never a stale copy
  assign dataIn = (strobeLow && pins.readWrite) ? memArr[pins.addr[3:0]]
                                               : ~lastData;
endmodule : emb_bus_partner

// ==== dv/tb_external_memory_io_bus.sv ====
// Self-checking bench for the external memory and I/O bus sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_external_memory_io_bus;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  emb_pkg::emb_req_t req = '0;
  logic consecutive_read_mode = 1'b0;
  logic ready, reqReady, rdataValid, cpu_clock_out;
  logic microstate_complete_n, consecReadActive;
  logic [emb_pkg::DATA_W-1:0] dataIn, rdata, gotData;
  emb_pkg::emb_pins_t pins, prevPins;
  logic [emb_pkg::ADDR_W-1:0] addrD2;
  logic [7:0] stallCycles = 8'h00;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int msLow, msLen, baseLen, mscPulses;

  always #5 clock = ~clock;

  emb_bus_ctrl emb_bus_ctrl_inst (.clock(clock), .rst(rst),
    .reqValid(reqValid), .req(req),
    .consecutive_read_mode(consecutive_read_mode), .ready(ready),
    .dataIn(dataIn), .reqReady(reqReady), .rdata(rdata),
    .rdataValid(rdataValid), .cpu_clock_out(cpu_clock_out),
    .microstate_complete_n(microstate_complete_n),
    .consecReadActive(consecReadActive), .pins(pins));
  emb_bus_partner emb_bus_partner_inst (.clock(clock), .rst(rst),
    .pins(pins), .stallCycles(stallCycles), .ready(ready), .dataIn(dataIn));

  // ==========================================================
  // Pin monitor, mid-cycle so every register has settled
  always @(negedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
    if (!rst)
    begin
      if (!pins.data_space_select_n || !pins.io_space_select_n)
        `CHK(pins.addr[19:16], emb_pkg::HIGH_ADDR_ZERO)
      if (pins.dataOe)
        `CHK(pins.readWrite, 1'b0)
      if (!pins.memory_strobe_n)
        msLow++;
      if (!microstate_complete_n)
        mscPulses++;
      if (rdataValid)
        gotData = rdata;
      if (prevPins.memory_strobe_n && !pins.memory_strobe_n)
      begin
        msLow = 1;
        if (!pins.readWrite)
        begin
          `CHK(prevPins.readWrite, 1'b0)
          `CHK(addrD2, pins.addr)
        end
      end
      if (!prevPins.memory_strobe_n && pins.memory_strobe_n)
      begin
        msLen = msLow;
        if (!prevPins.readWrite)
          `CHK(pins.dataOe, 1'b1)
      end
      if (prevPins.io_strobe_n != pins.io_strobe_n)
        `CHK(cpu_clock_out, 1'b1)
      if (prevPins.io_strobe_n && !pins.io_strobe_n && !pins.readWrite)
        `CHK(prevPins.addr, pins.addr)
      if (!prevPins.io_strobe_n && pins.io_strobe_n && !prevPins.readWrite)
      begin
        `CHK(pins.dataOut, prevPins.dataOut)
        `CHK(pins.dataOe, 1'b1)
      end
    end
    addrD2 = prevPins.addr;
    prevPins = pins;
  end

  // One request held until taken, then run back to idle
  task automatic do_op(input emb_pkg::emb_kind_t kind,
    input logic [19:0] addr, input logic [15:0] wdata);
    int guard;
    mscPulses = 0;
    gotData = 16'h0000;
    req.kind = kind;
    req.progSpace = 1'b0;
    req.addr = addr;
    req.wdata = wdata;
    reqValid = 1'b1;
    #1;
    for (guard = 0; !reqReady && guard < 10; guard++)
      @(negedge clock);
    @(negedge clock);
    reqValid = 1'b0;
    for (guard = 0; !reqReady && guard < 200; guard++)
      @(negedge clock);
    // A cycle that never returns to idle counts as a mismatch
    `CHK(reqReady, 1'b1)
    repeat (2) @(negedge clock);
    `CHK(mscPulses, 1)
  endtask : do_op

  // Data space round trip with junk in the upper address bits
  task automatic t_mem_space();
    do_op(emb_pkg::EMB_MEM_WR, 20'hF0003, 16'hA5C3);
    `CHK(msLen >= 2, 1'b1)
    baseLen = msLen;
    do_op(emb_pkg::EMB_MEM_RD, 20'hF0003, 16'h0000);
    `CHK(gotData, 16'hA5C3)
  endtask : t_mem_space

  // I/O space round trip
  task automatic t_io_space();
    do_op(emb_pkg::EMB_IO_WR, 20'hA0005, 16'h3C5A);
    do_op(emb_pkg::EMB_IO_RD, 20'hA0005, 16'h0000);
    `CHK(gotData, 16'h3C5A)
  endtask : t_io_space

  // Early ready low is ignored, a long stall stretches the strobe
  task automatic t_ready_wait();
    // Ready low through every software wait, high by the first sample
    stallCycles = 8'h07;
    do_op(emb_pkg::EMB_MEM_WR, 20'h00007, 16'h1234);
    `CHK(msLen, baseLen)
    stallCycles = 8'h0C;
    do_op(emb_pkg::EMB_MEM_WR, 20'h00007, 16'h1234);
    // Ready low at three falling-edge samples adds three clock-out cycles
    `CHK(msLen, baseLen + 6)
    do_op(emb_pkg::EMB_IO_RD, 20'h00007, 16'h0000);
    `CHK(gotData, 16'h1234)
    stallCycles = 8'h00;
  endtask : t_ready_wait

  // Mode bit follows the control input
  task automatic t_consecutive_read_mode_mode();
    consecutive_read_mode = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(consecReadActive, 1'b1)
    consecutive_read_mode = 1'b0;
    repeat (2) @(negedge clock);
    `CHK(consecReadActive, 1'b0)
  endtask : t_consecutive_read_mode_mode

  // Report and stop
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial
  begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_mem_space();
    t_io_space();
    t_ready_wait();
    t_consecutive_read_mode_mode();
    tally_and_finish();
  end
endmodule : tb_external_memory_io_bus
